// ==== tb/pld_led_board.sv ====
`timescale 1ns/10ps
module pld_led_board
    import pld_pkg::*;
(
    input wire logic [PLD_STRAP_PORTS-1:0] pull_i,
    input wire logic [PLD_PORTS-1:0] link_led_i,
    input wire logic [PLD_PORTS-1:0] speed_led_i,
    input wire logic [PLD_PORTS-1:0] dupcol_led_i,
    input wire logic [PLD_STRAP_PORTS-1:0] dupcol_oe_i,
    output logic [PLD_STRAP_PORTS-1:0] pin_o,
    output logic [PLD_PORTS-1:0] link_lit_o,
    output logic [PLD_PORTS-1:0] speed_lit_o,
    output logic [PLD_PORTS-1:0] dupcol_lit_o
);
    // Strap resistor sets the level whenever the pin is released
    always_comb begin
        for (int i = 0; i < PLD_STRAP_PORTS; i++) begin
            pin_o[i] = dupcol_oe_i[i] ? dupcol_led_i[i] : pull_i[i];
        end
    end
    assign link_lit_o = ~link_led_i;
    assign speed_lit_o = ~speed_led_i;
    // LED sits across the strap, so it lights on the opposite level
    assign dupcol_lit_o = {~dupcol_led_i[4:3], pin_o ^ pull_i};
endmodule

// ==== tb/pld_top_sva.sv ====
`timescale 1ns/10ps
module pld_top_sva
    import pld_pkg::*;
#(
    parameter int TICK_CYCLES = PLD_TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [PLD_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire pld_straps_t strap_pins_i,
    input wire pld_port_status_t [PLD_PORTS-1:0] port_status_i,
    input wire logic [PLD_PORTS-1:0] link_activity_led_o,
    input wire logic [PLD_PORTS-1:0] speed_led_o,
    input wire logic [PLD_PORTS-1:0] dupcol_led_o,
    input wire logic [PLD_STRAP_PORTS-1:0] dupcol_oe_o
);
    localparam int ON_MIN = 255 * TICK_CYCLES;
    localparam int ON_MAX = 256 * TICK_CYCLES + 2;
    // Margins absorb the unaligned first tick
    localparam int LINK_NORM = 97 * TICK_CYCLES + 4;
    localparam int DC_NORM = 353 * TICK_CYCLES + 4;
    int lit_run;
    int since_off;
    logic first_done;
    logic go_seen;
    logic [2:0] strap_cap;
    logic [PLD_PORTS-1:0] up_v, fast_v, act_v, fd_v, col_v;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    always_comb begin
        for (int i = 0; i < PLD_PORTS; i++) begin
            up_v[i] = port_status_i[i].link_up;
            fast_v[i] = port_status_i[i].speed100;
            act_v[i] = port_status_i[i].activity;
            fd_v[i] = port_status_i[i].full_duplex;
            col_v[i] = port_status_i[i].collision;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lit_run <= 0;
            since_off <= 0;
            first_done <= 1'h0;
            go_seen <= 1'h0;
        end else begin
            lit_run <= (link_activity_led_o == 5'h00) ? lit_run + 1 : 0;
            if (lit_run != 0 && link_activity_led_o == 5'h1F) first_done <= 1'h1;
            if (first_done && since_off <= DC_NORM) since_off <= since_off + 1;
            if (wb_ack_o && wb_we_i && wb_adr_i == PLD_ADDR_CTRL && wb_sel_i[0] && wb_dat_i[PLD_CTRL_GO_BIT]) begin
                go_seen <= 1'h1;
            end
        end
    end

    // Pin reads back the pull level only while undriven
    always_ff @(posedge clk_i) begin
        if (dupcol_oe_o == 3'h0) strap_cap <= strap_pins_i.dupcol;
    end

    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_lit_all;
        link_activity_led_o == 5'h00 && speed_led_o == 5'h00 && dupcol_led_o == {2'h0, ~strap_cap};
    endsequence

    a_ack_one_cycle: assert property ($rose(wb_stb_i) && wb_cyc_i |=> s_ack_pulse)
        else $error("ack is not a single pulse one cycle after request");
    a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_oe_settles: assert property ($fell(rst_i) |-> ##[1:4] (dupcol_oe_o == 3'h7))
        else $error("strap pins not driven after capture");
    a_oe_holds: assert property ($past(dupcol_oe_o) == 3'h7 |-> dupcol_oe_o == 3'h7)
        else $error("strap pin drive dropped");
    a_test_start: assert property ($rose(dupcol_oe_o[0]) && !strap_pins_i.wait_init |-> ##1 s_lit_all)
        else $error("on test pattern not shown after capture");
    a_wait_dark: assert property (dupcol_oe_o == 3'h7 && strap_pins_i.wait_init && !go_seen
        |-> link_activity_led_o == 5'h1F && speed_led_o == 5'h1F)
        else $error("test started without go");
    a_on_test_len: assert property (!first_done && lit_run != 0 && link_activity_led_o == 5'h1F
        |-> lit_run >= ON_MIN && lit_run <= ON_MAX)
        else $error("on test length wrong");
    a_speed_rate: assert property (since_off > LINK_NORM |-> speed_led_o == ~$past(up_v & fast_v))
        else $error("speed indicator wrong");
    a_link_steady: assert property (since_off > LINK_NORM
        |-> ((link_activity_led_o ^ ~$past(up_v)) & ~$past(act_v)) == 5'h00)
        else $error("link indicator wrong");
    a_dupcol_fd_lit: assert property (since_off > DC_NORM
        |-> (dupcol_led_o[4:3] & $past(up_v[4:3] & fd_v[4:3] & ~col_v[4:3])) == 2'h0)
        else $error("full duplex indicator not lit");
endmodule

bind pld_top pld_top_sva #(.TICK_CYCLES(TICK_CYCLES)) i_sva (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .strap_pins_i(strap_pins_i),
    .port_status_i(port_status_i),
    .link_activity_led_o(link_activity_led_o),
    .speed_led_o(speed_led_o),
    .dupcol_led_o(dupcol_led_o),
    .dupcol_oe_o(dupcol_oe_o)
);

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb import pld_pkg::*;;
    localparam int TICK = 4;
    logic clk, rst, cyc, stb, we, ack, wait_s, edi_s;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [2:0] pull, oe, pin;
    logic [4:0] ln, sp, dc, ln_lit, sp_lit, dc_lit;
    logic [14:0] lit;
    pld_port_status_t [PLD_PORTS-1:0] ps;
    pld_straps_t straps;
    int err_count = 0;
    int checks_done = 0;

    assign straps = {wait_s, edi_s, pin};
    assign lit = {dc_lit, sp_lit, ln_lit};
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    pld_top #(.TICK_CYCLES(TICK)) i_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .strap_pins_i(straps),
        .port_status_i(ps), .link_activity_led_o(ln), .speed_led_o(sp), .dupcol_led_o(dc), .dupcol_oe_o(oe));
    pld_led_board i_board (.pull_i(pull), .link_led_i(ln), .speed_led_i(sp), .dupcol_led_i(dc), .dupcol_oe_i(oe),
        .pin_o(pin), .link_lit_o(ln_lit), .speed_lit_o(sp_lit), .dupcol_lit_o(dc_lit));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1 && n < 50);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        if (n >= 50) chk(32'h0, 32'h1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'h0, a, 32'h0, 4'hF);
        chk(q, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        xfer(1'h1, a, d, s);
    endtask
    task automatic cw(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic boot(input logic w, input logic e, input logic [2:0] p);
        @(posedge clk);
        rst <= 1'h1;
        wait_s <= w;
        edi_s <= e;
        pull <= p;
        cw(16);
        rst <= 1'h0;
    endtask
    // Cycles between two successive changes of one indicator
    task automatic half(input int s, input int exp);
        int n;
        logic v;
        @(posedge clk);
        v = lit[s];
        n = 0;
        while (lit[s] === v && n < 200) begin
            @(posedge clk);
            n++;
        end
        v = lit[s];
        n = 0;
        while (lit[s] === v && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n), 32'(exp));
    endtask
    task automatic end_test(input string s);
        $display("test %s done, mismatches %0d", s, err_count);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        cw(20000);
        err_count++;
        finish_test;
    end

    initial begin
        rst = 1'h1;
        {cyc, stb, we, wait_s, edi_s} = 5'h00;
        {adr, sel, wdat, pull} = '0;
        ps = '0;
        boot(1'h0, 1'h0, 3'h5);
        ps[0] <= 5'h1C;
        ps[1] <= 5'h10;
        ps[3] <= 5'h1C;
        cw(8);
        chk(32'(lit), 32'h7FFF);
        rd(PLD_ADDR_STATUS, 32'h2A);
        cw(258 * TICK - 8);
        chk(32'(lit), 32'h0);
        cw(100 * TICK);
        chk(32'({lit[14:10] & 5'h1B, lit[9:0]}), 32'h252B);
        rd(PLD_ADDR_STATUS, 32'h2B);
        half(12, 10 * TICK);
        rd(8'h08, 32'h0);
        wr(PLD_ADDR_CTRL, 32'hF, 4'h0);
        rd(PLD_ADDR_CTRL, 32'h0);
        wr(PLD_ADDR_CTRL, 32'h6, 4'h1);
        rd(PLD_ADDR_CTRL, 32'h6);
        cw(20);
        chk(32'(lit[4:0]), 32'h0B);
        ps[3] <= 5'h1D;
        repeat (12) begin
            cw(7);
            chk(32'(lit[13:12]), 32'h2);
        end
        wr(PLD_ADDR_CTRL, 32'h0, 4'h1);
        half(13, 10 * TICK);
        ps[0] <= 5'h1E;
        half(0, 10 * TICK);
        ps[0] <= 5'h1D;
        half(10, 10 * TICK);
        ps[0] <= 5'h1C;
        ps[3] <= 5'h1C;
        wr(PLD_ADDR_CTRL, 32'h8, 4'h1);
        ps[1] <= 5'h11;
        half(10, 5 * TICK);
        chk(32'(lit[11]), 32'h0);
        ps[1] <= 5'h10;
        cw(4);
        repeat (6) begin
            cw(7);
            chk(32'(lit[11:10]), 32'h0);
        end
        ps[4] <= 5'h19;
        half(11, 5 * TICK);
        end_test("single");
        boot(1'h1, 1'h0, 3'h2);
        cw(20);
        chk(32'(lit), 32'h0);
        rd(PLD_ADDR_STATUS, 32'h91);
        wr(PLD_ADDR_CTRL, 32'h3, 4'h1);
        cw(6);
        chk(32'(lit), 32'h7FFF);
        rd(PLD_ADDR_STATUS, 32'h96);
        cw(300 * TICK - 12);
        chk(32'(lit), 32'h7C00);
        cw(220 * TICK);
        chk(32'(lit), 32'h033B);
        end_test("dual");
        boot(1'h0, 1'h1, 3'h0);
        cw(8);
        rd(PLD_ADDR_STATUS, 32'h46);
        end_test("strap");
        finish_test;
    end
endmodule

// ==== verilog/pld_pkg.sv ====
// Contract
// - Three indicator outputs per port
// - Test pattern on all indicators at power-on
// - Wait strap high: colour from config bit
// - Wait strap low: colour from sampled pin
// - Wait strap high: test starts on go write
// - Link LEDs: 0 for 1.28s, 1 for 0.48s
// - Link LED on when up, 10 Hz activity
// - Speed LED follows test; on at 100M
// - Dupcol 0-2: inverted strap, then strap level
// - Dupcol 0-2: on full duplex, flash on collision or link down, else off
// - Dupcol 3-4: dupcol test timing, duplex/collision display
// - Duplex-only option: no collision blinking
// - Hub option: dupcol0 flashes 20 Hz, 10M collisions
// - Hub option: dupcol1 flashes 20 Hz, 100M collisions
// - Dual colour: dupcol on-test lasts 2.56s
package pld_pkg;
    localparam int PLD_PORTS = 5;
    localparam int PLD_STRAP_PORTS = 3;
    localparam int PLD_ADDR_W = 8;
    localparam int PLD_CLK_MHZ = 200;
    localparam int PLD_TICK_MS = 5;
    localparam int PLD_TICK_CYCLES = PLD_TICK_MS * 1000 * PLD_CLK_MHZ;
    localparam int PLD_ON_MS = 1280;
    localparam int PLD_OFF_MS = 480;
    localparam int PLD_DUAL_ON_MS = 2560;
    localparam int PLD_FLASH20_HALF_MS = 25;
    localparam int PLD_TCNT_W = 10;
    localparam logic [PLD_TCNT_W-1:0] PLD_ON_TICKS = PLD_TCNT_W'(PLD_ON_MS / PLD_TICK_MS);
    localparam logic [PLD_TCNT_W-1:0] PLD_OFF_TICKS = PLD_TCNT_W'(PLD_OFF_MS / PLD_TICK_MS);
    localparam logic [PLD_TCNT_W-1:0] PLD_DUAL_ON_TICKS = PLD_TCNT_W'(PLD_DUAL_ON_MS / PLD_TICK_MS);
    localparam logic [2:0] PLD_FLASH20_TICKS = 3'(PLD_FLASH20_HALF_MS / PLD_TICK_MS);
    localparam logic [1:0] PLD_SETTLE_CYCLES = 2'h2;
    localparam logic [PLD_ADDR_W-1:0] PLD_ADDR_CTRL = 8'h00;
    localparam logic [PLD_ADDR_W-1:0] PLD_ADDR_STATUS = 8'h04;
    localparam int PLD_CTRL_COLOUR_BIT = 0;
    localparam int PLD_CTRL_GO_BIT = 1;
    localparam int PLD_CTRL_DUPONLY_BIT = 2;
    localparam int PLD_CTRL_HUB_BIT = 3;
    localparam int PLD_ST_PHASE_LSB = 0;
    localparam int PLD_ST_DUAL_BIT = 2;
    localparam int PLD_ST_STRAP_LSB = 3;
    localparam int PLD_ST_MODE_BIT = 6;
    localparam int PLD_ST_WAIT_BIT = 7;

    typedef struct packed {
        logic hub_collision_option;
        logic duplex_only_option;
        logic indicator_test_go;
        logic colour_mode_cfg_bit;
    } pld_ctrl_t;

    localparam pld_ctrl_t PLD_CTRL_RESET = 4'h0;

    typedef struct packed {
        logic link_up;
        logic speed100;
        logic full_duplex;
        logic activity;
        logic collision;
    } pld_port_status_t;

    typedef struct packed {
        logic wait_init;
        logic serial_mem_data_in;
        logic [PLD_STRAP_PORTS-1:0] dupcol;
    } pld_straps_t;

    typedef enum logic [1:0] {
        ST_CAPTURE = 2'b00,
        ST_WAIT_EN = 2'b01,
        ST_TEST = 2'b10,
        ST_NORMAL = 2'b11
    } pld_phase_t;
endpackage

// ==== verilog/pld_sync.sv ====
`timescale 1ns/10ps
module pld_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    // Meta stage is read only by the second stage
    logic [W-1:0] meta;

    always_ff @(posedge clk_i) begin
        meta <= d_i;
        q_o <= meta;
    end
endmodule

// ==== verilog/pld_timebase.sv ====
`timescale 1ns/10ps
module pld_timebase
    import pld_pkg::*;
#(
    parameter int TICK_CYCLES = PLD_TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic tick_o,
    output logic blink10_o,
    output logic blink20_o
);
    localparam int CW = $clog2(TICK_CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic [2:0] sub;
        logic tick;
        logic b10;
        logic b20;
    } pld_tb_state_t;

    pld_tb_state_t s;
    pld_tb_state_t next_s;

    // Free-running from reset release; all LED timing shares it
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        next_s.cnt = s.cnt + CW'(1);
        if (s.cnt == CW'(TICK_CYCLES - 1)) begin
            next_s.cnt = '0;
            next_s.tick = 1'b1;
        end
        if (s.tick) begin
            next_s.sub = s.sub + 3'h1;
            if (s.sub == PLD_FLASH20_TICKS - 3'h1) begin
                next_s.sub = 3'h0;
                next_s.b20 = ~s.b20;
                if (s.b20) begin
                    next_s.b10 = ~s.b10;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick_o = s.tick;
    assign blink10_o = s.b10;
    assign blink20_o = s.b20;
endmodule

// ==== verilog/pld_top.sv ====
`timescale 1ns/10ps
module pld_top
    import pld_pkg::*;
#(
    parameter int TICK_CYCLES = PLD_TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [PLD_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire pld_straps_t strap_pins_i,
    input wire pld_port_status_t [PLD_PORTS-1:0] port_status_i,
    output logic [PLD_PORTS-1:0] link_activity_led_o,
    output logic [PLD_PORTS-1:0] speed_led_o,
    output logic [PLD_PORTS-1:0] dupcol_led_o,
    output logic [PLD_STRAP_PORTS-1:0] dupcol_oe_o
);
    typedef struct packed {
        pld_phase_t phase;
        logic [1:0] settle;
        logic [PLD_TCNT_W-1:0] tcnt;
        logic dual;
        pld_straps_t straps;
        pld_ctrl_t ctrl;
        logic ack;
        logic [31:0] rdata;
        logic [PLD_PORTS-1:0] link_led;
        logic [PLD_PORTS-1:0] speed_led;
        logic [PLD_PORTS-1:0] dup_led;
        logic [PLD_STRAP_PORTS-1:0] oe;
    } pld_state_t;

    // LEDs dark and strap pins released while in reset
    localparam pld_state_t RESET_STATE = '{
        phase: ST_CAPTURE,
        settle: 2'h0,
        tcnt: '0,
        dual: 1'b0,
        straps: '0,
        ctrl: PLD_CTRL_RESET,
        ack: 1'b0,
        rdata: 32'h0,
        link_led: '1,
        speed_led: '1,
        dup_led: '1,
        oe: '0
    };

    pld_state_t s;
    pld_state_t next_s;

    pld_straps_t straps_sync;
    logic tick;
    logic blink10;
    logic blink20;

    pld_sync #(
        .W($bits(pld_straps_t))
    ) u_strap_sync (
        .clk_i(clk_i),
        .d_i(strap_pins_i),
        .q_o(straps_sync)
    );

    pld_timebase #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timebase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick),
        .blink10_o(blink10),
        .blink20_o(blink20)
    );

    // Sequence decode shared by all ports
    logic [PLD_TCNT_W-1:0] dup_on_len;
    logic [PLD_TCNT_W-1:0] link_end;
    logic [PLD_TCNT_W-1:0] test_end;
    logic in_test;
    logic link_on_test;
    logic link_off_test;
    logic link_normal;
    logic dup_on_test;
    logic dup_normal;

    assign dup_on_len = s.dual ? PLD_DUAL_ON_TICKS : PLD_ON_TICKS;
    assign link_end = PLD_ON_TICKS + PLD_OFF_TICKS;
    assign test_end = dup_on_len + PLD_OFF_TICKS;
    assign in_test = (s.phase == ST_TEST);
    assign link_on_test = in_test && (s.tcnt < PLD_ON_TICKS);
    assign link_off_test = in_test && (s.tcnt >= PLD_ON_TICKS) && (s.tcnt < link_end);
    assign link_normal = (s.phase == ST_NORMAL) || (in_test && (s.tcnt >= link_end));
    assign dup_on_test = in_test && (s.tcnt < dup_on_len);
    assign dup_normal = (s.phase == ST_NORMAL);

    // Hub collision sources across all ports
    logic slow_collision_seen;
    logic fast_collision_seen;
    logic [PLD_PORTS-1:0] slow_col_port;
    logic [PLD_PORTS-1:0] fast_col_port;

    // Off level per dupcol pin: strap for strapped pins, high otherwise
    logic [PLD_PORTS-1:0] dup_off;
    logic [PLD_PORTS-1:0] link_n;
    logic [PLD_PORTS-1:0] speed_n;
    logic [PLD_PORTS-1:0] dup_n;

    genvar gi;
    generate
        for (gi = 0; gi < PLD_PORTS; gi++) begin : g_port
            pld_port_status_t st;
            logic dup_on;
            logic flash10;
            logic disp;

            assign st = port_status_i[gi];
            assign slow_col_port[gi] = st.link_up && !st.speed100 && !st.full_duplex && st.collision;
            assign fast_col_port[gi] = st.link_up && st.speed100 && !st.full_duplex && st.collision;

            if (gi < PLD_STRAP_PORTS) begin : g_strap
                assign dup_off[gi] = s.straps.dupcol[gi];
            end else begin : g_plain
                assign dup_off[gi] = 1'b1;
            end

            assign dup_on = ~dup_off[gi];
            assign flash10 = blink10 ? dup_off[gi] : dup_on;

            // Active low; activity flashes about the lit level
            always_comb begin
                if (link_on_test) begin
                    link_n[gi] = 1'b0;
                end else if (link_normal) begin
                    if (!st.link_up) begin
                        link_n[gi] = 1'b1;
                    end else if (st.activity) begin
                        link_n[gi] = blink10;
                    end else begin
                        link_n[gi] = 1'b0;
                    end
                end else begin
                    link_n[gi] = 1'b1;
                end
            end

            always_comb begin
                if (link_on_test) begin
                    speed_n[gi] = 1'b0;
                end else if (link_normal) begin
                    speed_n[gi] = !(st.link_up && st.speed100);
                end else begin
                    speed_n[gi] = 1'b1;
                end
            end

            always_comb begin
                if (s.ctrl.duplex_only_option) begin
                    disp = (st.link_up && st.full_duplex) ? dup_on : dup_off[gi];
                end else if (!st.link_up) begin
                    if (gi < PLD_STRAP_PORTS) begin
                        disp = flash10;
                    end else begin
                        disp = dup_off[gi];
                    end
                end else if (st.collision) begin
                    disp = flash10;
                end else begin
                    disp = st.full_duplex ? dup_on : dup_off[gi];
                end
            end

            if (gi == 0) begin : g_hub10
                always_comb begin
                    if (dup_on_test) begin
                        dup_n[gi] = dup_on;
                    end else if (!dup_normal) begin
                        dup_n[gi] = dup_off[gi];
                    end else if (s.ctrl.hub_collision_option) begin
                        dup_n[gi] = (slow_collision_seen && blink20) ? dup_on : dup_off[gi];
                    end else begin
                        dup_n[gi] = disp;
                    end
                end
            end else if (gi == 1) begin : g_hub100
                always_comb begin
                    if (dup_on_test) begin
                        dup_n[gi] = dup_on;
                    end else if (!dup_normal) begin
                        dup_n[gi] = dup_off[gi];
                    end else if (s.ctrl.hub_collision_option) begin
                        dup_n[gi] = (fast_collision_seen && blink20) ? dup_on : dup_off[gi];
                    end else begin
                        dup_n[gi] = disp;
                    end
                end
            end else begin : g_nohub
                always_comb begin
                    if (dup_on_test) begin
                        dup_n[gi] = dup_on;
                    end else if (!dup_normal) begin
                        dup_n[gi] = dup_off[gi];
                    end else begin
                        dup_n[gi] = disp;
                    end
                end
            end
        end
    endgenerate

    assign slow_collision_seen = |slow_col_port;
    assign fast_collision_seen = |fast_col_port;

    // Register bus
    logic req;
    logic wr_ctrl;
    logic [31:0] status_word;
    logic [31:0] ctrl_word;

    assign req = wb_cyc_i && wb_stb_i && !s.ack;
    assign wr_ctrl = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == PLD_ADDR_CTRL);

    always_comb begin
        ctrl_word = 32'h0;
        ctrl_word[PLD_CTRL_COLOUR_BIT] = s.ctrl.colour_mode_cfg_bit;
        ctrl_word[PLD_CTRL_GO_BIT] = s.ctrl.indicator_test_go;
        ctrl_word[PLD_CTRL_DUPONLY_BIT] = s.ctrl.duplex_only_option;
        ctrl_word[PLD_CTRL_HUB_BIT] = s.ctrl.hub_collision_option;
    end

    always_comb begin
        status_word = 32'h0;
        status_word[PLD_ST_PHASE_LSB +: 2] = s.phase;
        status_word[PLD_ST_DUAL_BIT] = s.dual;
        status_word[PLD_ST_STRAP_LSB +: PLD_STRAP_PORTS] = s.straps.dupcol;
        status_word[PLD_ST_MODE_BIT] = s.straps.serial_mem_data_in;
        status_word[PLD_ST_WAIT_BIT] = s.straps.wait_init;
    end

    always_comb begin
        next_s = s;

        // One-cycle ack; unmapped reads give zero, unmapped writes vanish
        next_s.ack = req;
        next_s.rdata = 32'h0;
        if (req && !wb_we_i) begin
            if (wb_adr_i == PLD_ADDR_CTRL) begin
                next_s.rdata = ctrl_word;
            end else if (wb_adr_i == PLD_ADDR_STATUS) begin
                next_s.rdata = status_word;
            end
        end
        if (wr_ctrl) begin
            next_s.ctrl.colour_mode_cfg_bit = wb_dat_i[PLD_CTRL_COLOUR_BIT];
            next_s.ctrl.indicator_test_go = wb_dat_i[PLD_CTRL_GO_BIT];
            next_s.ctrl.duplex_only_option = wb_dat_i[PLD_CTRL_DUPONLY_BIT];
            next_s.ctrl.hub_collision_option = wb_dat_i[PLD_CTRL_HUB_BIT];
        end

        unique case (s.phase)
            ST_CAPTURE: begin
                // Synchroniser must fill before straps are trusted
                next_s.settle = s.settle + 2'h1;
                if (s.settle == PLD_SETTLE_CYCLES) begin
                    next_s.straps = straps_sync;
                    next_s.oe = '1;
                    next_s.tcnt = '0;
                    if (straps_sync.wait_init) begin
                        next_s.phase = ST_WAIT_EN;
                    end else begin
                        next_s.dual = straps_sync.serial_mem_data_in;
                        next_s.phase = ST_TEST;
                    end
                end
            end
            ST_WAIT_EN: begin
                // Colour must be written no later than go; it is frozen here
                if (s.ctrl.indicator_test_go) begin
                    next_s.dual = s.ctrl.colour_mode_cfg_bit;
                    next_s.tcnt = '0;
                    next_s.phase = ST_TEST;
                end
            end
            ST_TEST: begin
                if (tick) begin
                    next_s.tcnt = s.tcnt + PLD_TCNT_W'(1);
                    if (s.tcnt == test_end - PLD_TCNT_W'(1)) begin
                        next_s.phase = ST_NORMAL;
                    end
                end
            end
            ST_NORMAL: begin
                next_s.phase = ST_NORMAL;
            end
        endcase

        next_s.link_led = link_n;
        next_s.speed_led = speed_n;
        next_s.dup_led = dup_n;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_o = s.rdata;
    assign wb_ack_o = s.ack;
    assign link_activity_led_o = s.link_led;
    assign speed_led_o = s.speed_led;
    assign dupcol_led_o = s.dup_led;
    assign dupcol_oe_o = s.oe;
endmodule
